// ### logic/mphy_consts.svh
// constants for the phy-side media independent interface
`ifndef MPHY_CONSTS_SVH
`define MPHY_CONSTS_SVH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define MPHY_CLK_PERIOD_PS 32'd4000
`define MPHY_MII_PERIOD_PS 32'd40000
`define MPHY_SYM_PERIOD_PS 32'd8000
`define MPHY_MII_DIV (`MPHY_MII_PERIOD_PS / `MPHY_CLK_PERIOD_PS)
`define MPHY_SYM_DIV (`MPHY_SYM_PERIOD_PS / `MPHY_CLK_PERIOD_PS)
`define MPHY_MII_HALF (`MPHY_MII_DIV / 32'd2)
`define MPHY_SYM_HALF (`MPHY_SYM_DIV / 32'd2)

// ----------------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------------
`define MPHY_NIB_W 4
`define MPHY_NIB_RST 4'h0
`define MPHY_DIV_CNT_W 8

`endif

// ### logic/mphy_pkg.sv
// types shared by the phy-side media independent interface
package mphy_pkg;

    typedef enum logic [1:0] {
        MPHY_TX_IDLE = 2'b01,
        MPHY_TX_FRAME = 2'b10
    } mphy_tx_state_t;

    typedef enum logic [1:0] {
        MPHY_RX_IDLE = 2'b01,
        MPHY_RX_FRAME = 2'b10
    } mphy_rx_state_t;

endpackage : mphy_pkg

// ### logic/mphy_clkdiv.sv
// clock divider giving a square output and edge enables
`timescale 1ns/10ps
`include "mphy_consts.svh"

module mphy_clkdiv #(
    parameter logic [`MPHY_DIV_CNT_W-1:0] HALF = 8'h05
) (
    input wire logic clock,
    input wire logic rst,
    output logic clk_out,
    output logic rise,
    output logic fall
);
    logic [`MPHY_DIV_CNT_W-1:0] count;
    logic tick;

    assign tick = (count == HALF - 8'h01);
    // pulses lead the output edge by one cycle so users act with it
    assign rise = tick & ~clk_out;
    assign fall = tick & clk_out;

    always_ff @(posedge clock) begin
        if (rst || tick) begin
            count <= 8'h00;
        end else begin
            count <= count + 8'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            clk_out <= 1'b0;
        end else if (tick) begin
            clk_out <= ~clk_out;
        end
    end

endmodule : mphy_clkdiv

// ### logic/mphy_mii.sv
// phy-side media independent interface: mii pins to internal nibbles
//
// Operation
// - capture transmit nibble when enable high
// - drive free-running transmit clock to MAC
// - enable and error give invalid symbol
// - present receive nibble each valid period
// - drive free-running receive clock to MAC
// - raise data valid with decoded nibbles
// - valid covers frame from delimiter, excludes end
// - receive error changes only with clock
// - hold receive error on frame error
// - carrier sense when either medium busy
// - accept transmit nibbles at 25 MHz
// - derive 125 MHz internal symbol rate
`timescale 1ns/10ps
`include "mphy_consts.svh"

module mphy_mii
    import mphy_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    // mii transmit side
    output logic tx_clk,
    input wire logic [`MPHY_NIB_W-1:0] txd,
    input wire logic tx_en,
    input wire logic tx_er,
    // mii receive side
    output logic rx_clk,
    output logic [`MPHY_NIB_W-1:0] rxd,
    output logic rx_dv,
    output logic rx_er,
    output logic crs,
    // internal symbol-rate enable
    output logic sym_tick,
    // toward the transmit coder
    output logic [`MPHY_NIB_W-1:0] tx_nib_data,
    output logic tx_nib_valid,
    output logic tx_nib_error,
    output logic tx_busy,
    // from the receive decoder
    input wire logic [`MPHY_NIB_W-1:0] rx_nib_data,
    input wire logic rx_nib_valid,
    input wire logic rx_nib_frame,
    input wire logic rx_nib_error,
    input wire logic rx_line_busy
);
    // ------------------------------------------------------------------
    // clocks
    // ------------------------------------------------------------------
    logic mii_fall;
    logic sym_rise;

    mphy_clkdiv #(
        .HALF(`MPHY_DIV_CNT_W'(`MPHY_MII_HALF))
    ) u_mii_div (
        .clock(clock),
        .rst(rst),
        .clk_out(tx_clk),
        .rise(),
        .fall(mii_fall)
    );

    // receive clock shares the transmit clock
    assign rx_clk = tx_clk;

    mphy_clkdiv #(
        .HALF(`MPHY_DIV_CNT_W'(`MPHY_SYM_HALF))
    ) u_sym_div (
        .clock(clock),
        .rst(rst),
        .clk_out(),
        .rise(sym_rise),
        .fall()
    );

    assign sym_tick = sym_rise;

    // ------------------------------------------------------------------
    // transmit pin synchronisers
    // ------------------------------------------------------------------
    logic [`MPHY_NIB_W+1:0] tx_meta;
    logic [`MPHY_NIB_W+1:0] tx_sync;

    // first stage may settle late; nothing but the second stage reads it
    always_ff @(posedge clock) begin
        if (rst) begin
            tx_meta <= '0;
        end else begin
            tx_meta <= {tx_er, tx_en, txd};
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            tx_sync <= '0;
        end else begin
            tx_sync <= tx_meta;
        end
    end

    logic s_en;
    logic s_er;
    logic [`MPHY_NIB_W-1:0] s_txd;

    assign s_txd = tx_sync[`MPHY_NIB_W-1:0];
    assign s_en = tx_sync[`MPHY_NIB_W];
    assign s_er = tx_sync[`MPHY_NIB_W+1];

    // ------------------------------------------------------------------
    // transmit capture
    // ------------------------------------------------------------------
    // the mac launches on the rising edge; sampling at the falling edge
    // leaves half a period, more than the two-flop latency needs
    mphy_tx_state_t tx_state;
    mphy_tx_state_t next_tx_state;

    always_comb begin
        next_tx_state = tx_state;
        case (tx_state)
            MPHY_TX_IDLE: begin
                if (mii_fall && s_en) begin
                    next_tx_state = MPHY_TX_FRAME;
                end
            end
            MPHY_TX_FRAME: begin
                if (mii_fall && !s_en) begin
                    next_tx_state = MPHY_TX_IDLE;
                end
            end
            default: begin
                next_tx_state = MPHY_TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            tx_state <= MPHY_TX_IDLE;
        end else begin
            tx_state <= next_tx_state;
        end
    end

    assign tx_busy = (tx_state == MPHY_TX_FRAME);

    always_ff @(posedge clock) begin
        if (rst) begin
            tx_nib_valid <= 1'b0;
        end else begin
            tx_nib_valid <= mii_fall & s_en;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            tx_nib_data <= `MPHY_NIB_RST;
        end else if (mii_fall && s_en) begin
            tx_nib_data <= s_txd;
        end
    end

    // the error flag lasts one nibble period, so the coder swaps in an
    // invalid symbol for exactly the nibble it came with
    always_ff @(posedge clock) begin
        if (rst) begin
            tx_nib_error <= 1'b0;
        end else if (mii_fall) begin
            tx_nib_error <= s_en & s_er;
        end
    end

    // ------------------------------------------------------------------
    // receive holding register
    // ------------------------------------------------------------------
    // one nibble held between the decoder and the pins; decoder rate
    // matches the pin rate so a single stage is enough
    logic hold_full;
    logic hold_frame;
    logic hold_err;
    logic [`MPHY_NIB_W-1:0] hold_data;

    always_ff @(posedge clock) begin
        if (rst) begin
            hold_full <= 1'b0;
        end else if (rx_nib_valid) begin
            // a new nibble wins over the drain in the same cycle
            hold_full <= 1'b1;
        end else if (mii_fall) begin
            hold_full <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            hold_data <= `MPHY_NIB_RST;
        end else if (rx_nib_valid) begin
            hold_data <= rx_nib_data;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            hold_frame <= 1'b0;
        end else if (rx_nib_valid) begin
            hold_frame <= rx_nib_frame;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            hold_err <= 1'b0;
        end else if (rx_nib_valid) begin
            hold_err <= rx_nib_error;
        end
    end

    // ------------------------------------------------------------------
    // receive pins
    // ------------------------------------------------------------------
    mphy_rx_state_t rx_state;
    mphy_rx_state_t next_rx_state;
    logic take;

    // the decoder withholds the end delimiter, so a frame nibble in the
    // holding stage is exactly a nibble to present
    assign take = hold_full & hold_frame;

    always_comb begin
        next_rx_state = rx_state;
        case (rx_state)
            MPHY_RX_IDLE: begin
                if (mii_fall && take) begin
                    next_rx_state = MPHY_RX_FRAME;
                end
            end
            MPHY_RX_FRAME: begin
                if (mii_fall && !take) begin
                    next_rx_state = MPHY_RX_IDLE;
                end
            end
            default: begin
                next_rx_state = MPHY_RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rx_state <= MPHY_RX_IDLE;
        end else begin
            rx_state <= next_rx_state;
        end
    end

    // valid spans frame, no end delimiter
    assign rx_dv = (rx_state == MPHY_RX_FRAME);

    // outputs move with the falling edge so they are steady at the rise
    always_ff @(posedge clock) begin
        if (rst) begin
            rxd <= `MPHY_NIB_RST;
        end else if (mii_fall) begin
            rxd <= take ? hold_data : `MPHY_NIB_RST;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rx_er <= 1'b0;
        end else if (mii_fall) begin
            rx_er <= take & hold_err;
        end
    end

    // ------------------------------------------------------------------
    // carrier sense
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            crs <= 1'b0;
        end else begin
            crs <= tx_busy | rx_line_busy;
        end
    end

endmodule : mphy_mii

// ### testbench/mphy_mac_model.sv
// behavioural mac side driving the transmit pins
`timescale 1ns/10ps
module mphy_mac_model (
    input logic tx_clk,
    input logic nib_en,
    input logic [3:0] nib_d,
    input logic nib_er,
    output logic [3:0] txd = 4'h0,
    output logic tx_en = 1'b0,
    output logic tx_er = 1'b0
);
    // pins move on the clock rise
    always @(posedge tx_clk) begin
        // idle data lines never repeat the last nibble
        txd <= nib_en ? nib_d : ~txd;
        tx_en <= nib_en;
        tx_er <= nib_er;
    end
endmodule : mphy_mac_model

// ### testbench/mphy_mii_properties.sv
// assertion checker for the mii pins of the phy-side block
`timescale 1ns/10ps
module mphy_mii_properties (
    input logic clock,
    input logic rst,
    input logic tx_clk,
    input logic [3:0] txd,
    input logic tx_en,
    input logic tx_er,
    input logic rx_clk,
    input logic [3:0] rxd,
    input logic rx_dv,
    input logic rx_er,
    input logic crs,
    input logic sym_tick,
    input logic [3:0] tx_nib_data,
    input logic tx_nib_valid,
    input logic tx_nib_error,
    input logic tx_busy,
    input logic [3:0] rx_nib_data,
    input logic rx_nib_valid,
    input logic rx_nib_frame,
    input logic rx_nib_error,
    input logic rx_line_busy
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    logic [3:0] pend_d;
    logic pend_dv, pend_er;
    // mirror of the holding stage; a push in the drain cycle survives it
    always_ff @(posedge clock) begin
        if (rx_nib_valid) begin
            pend_d <= rx_nib_data;
        end
        if (rst || rx_nib_valid ||
            ($fell(rx_clk) && !$past(rx_nib_valid))) begin
            pend_dv <= !rst && rx_nib_valid && rx_nib_frame;
            pend_er <= !rst && rx_nib_valid && rx_nib_error;
        end
    end
    sequence high_half; tx_clk [*5]; endsequence
    sequence low_half; !tx_clk [*5]; endsequence
    sequence rx_high_half; rx_clk [*5]; endsequence
    sequence rx_low_half; !rx_clk [*5]; endsequence
    clk_period_a: assert property ($rose(tx_clk) |->
        high_half ##1 low_half ##1 tx_clk) else $error("bad clock period");
    rx_period_a: assert property ($rose(rx_clk) |->
        rx_high_half ##1 rx_low_half ##1 rx_clk) else $error("bad rx clock");
    sym_live_a: assert property (!sym_tick |=> sym_tick)
        else $error("symbol tick missing");
    sym_rate_a: assert property (sym_tick |=> !sym_tick ##1 sym_tick)
        else $error("bad symbol tick");
    tx_take_a: assert property (tx_nib_valid |-> $fell(tx_clk) &&
        $past(tx_en, 3) && tx_nib_data == $past(txd, 3))
        else $error("bad captured nibble");
    tx_error_a: assert property (tx_nib_valid |->
        tx_nib_error == $past(tx_er, 3)) else $error("bad nibble error");
    tx_idle_a: assert property ($fell(tx_clk) && !$past(tx_en, 3) |->
        !tx_nib_valid && !tx_nib_error && !tx_busy)
        else $error("idle input not ignored");
    rx_sync_a: assert property ($changed({rxd, rx_dv, rx_er}) |->
        $fell(rx_clk) && $fell(tx_clk)) else $error("rx pins off clock");
    rx_show_a: assert property ($fell(rx_clk) |->
        rx_dv == $past(pend_dv) && rx_er == $past(pend_er) &&
        rxd == (rx_dv ? $past(pend_d) : 4'h0)) else $error("bad rx nibble");
    carrier_a: assert property (1'b1 |=>
        crs == ($past(tx_busy) || $past(rx_line_busy))) else $error("bad crs");
endmodule : mphy_mii_properties
bind mphy_mii mphy_mii_properties u_mphy_mii_properties (.*);

// ### testbench/testbench.sv
// self-checking bench for the phy-side mii block
`timescale 1ns/10ps
module testbench;
    logic clock = 1'b0, rst = 1'b1;
    logic tx_clk, rx_clk, rx_dv, rx_er, crs, sym_tick, tx_en, tx_er;
    logic tx_nib_valid, tx_nib_error, tx_busy;
    logic [3:0] txd, rxd, tx_nib_data, nib_d = 4'h0, rx_nib_data = 4'h0;
    logic nib_en = 1'b0, nib_er = 1'b0, rx_nib_valid = 1'b0;
    logic rx_nib_frame = 1'b0, rx_nib_error = 1'b0, rx_line_busy = 1'b0;
    int n_errors = 0, num_checks = 0, cycles = 0;
    logic [4:0] seen[$];
    mphy_mii u_mphy_mii (.*);
    mphy_mac_model u_mphy_mac_model (.*);
    always #2 clock = ~clock;
    task automatic chk(logic [7:0] got, logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude
    // nibbles to the coder; the whole run needs well under 400 cycles
    always @(negedge clock) begin
        if (tx_nib_valid) begin
            seen.push_back({tx_nib_error, tx_nib_data});
        end
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            conclude();
        end
    end
    task automatic send(logic [5:0] req);
        @(negedge clock);
        {nib_er, nib_en, nib_d} = req;
        @(posedge tx_clk);
    endtask : send
    task automatic t_tx();
        for (int i = 0; i < 8; i++) begin
            send({1'(i == 5), 1'b1, 4'(2 * i + 1)});
        end
        @(negedge clock);
        chk(8'(crs), 8'h01);
        // error raised with enable low must be dropped
        repeat (3) send(6'h2a);
        @(negedge clock);
        chk(8'(seen.size()), 8'h08);
        foreach (seen[i]) begin
            chk(8'(seen[i]), {3'h0, 1'(i == 5), 4'(2 * i + 1)});
        end
        chk(8'(crs), 8'h00);
    endtask : t_tx
    task automatic push(logic [5:0] req, logic [7:0] exp);
        @(negedge clock);
        {rx_nib_error, rx_nib_frame, rx_nib_data} = req;
        rx_nib_valid = 1'b1;
        @(negedge clock);
        rx_nib_valid = 1'b0;
        @(negedge tx_clk);
        // sampled on the receive clock rise
        @(posedge rx_clk);
        @(negedge clock);
        chk({2'h0, rx_er, rx_dv, rxd}, exp);
    endtask : push
    task automatic t_rx();
        rx_line_busy = 1'b1;
        @(negedge tx_clk);
        push(6'h15, 8'h15);
        push(6'h1d, 8'h1d);
        push(6'h3f, 8'h3f);
        // end-of-stream nibble stays off the pins
        push(6'h07, 8'h00);
        chk(8'(crs), 8'h01);
        rx_line_busy = 1'b0;
        repeat (2) @(negedge clock);
        chk(8'(crs), 8'h00);
    endtask : t_rx
    initial begin
        repeat (4) @(negedge clock);
        rst = 1'b0;
        t_tx();
        t_rx();
        conclude();
    end
endmodule : testbench
